// ===== core/clkctl_defs.vh
// Register map, field positions, reset values and timing constants of the clock controller
`ifndef CLKCTL_DEFS_VH
`define CLKCTL_DEFS_VH
`define ADDR_CLOCK_SPEED_CONTROL_0 8'h8f
`define ADDR_PLL_CONTROL 8'ha3
`define ADDR_PLL_DIVIDER 8'ha4
`define ADDR_CLOCK_SPEED_CONTROL_1 8'haf
`define RST_CLOCK_SPEED_CONTROL_0 8'h00
`define RST_CLOCK_SPEED_CONTROL_1 1'b0
`define RST_PLL_DIVIDER 8'h00
`define BIT_DOUBLE_SPEED 0
`define BIT_TIMER0_SPEED 1
`define BIT_TIMER1_SPEED 2
`define BIT_TIMER2_SPEED 3
`define BIT_SERIAL_SPEED 4
`define BIT_COUNTER_ARRAY_SPEED 5
`define BIT_WATCHDOG_SPEED 6
`define BIT_TWO_WIRE_SPEED 7
`define BIT_SPI_SPEED 0
`define BIT_LOCK 0
`define BIT_PLL_ENABLE 1
`define BIT_BYPASS_48 2
`define FIELD_FEEDBACK_HI 7
`define FIELD_FEEDBACK_LO 4
`define FIELD_REFERENCE_HI 3
`define FIELD_REFERENCE_LO 0
`define CLOCK_HZ 200000000
`define USB_HZ 48000000
`define VCO_PERIOD_INIT (`CLOCK_HZ / `USB_HZ)
`define VCO_PERIOD_MIN 8'h02
`define VCO_PERIOD_MAX 8'hff
`define LOCK_TOLERANCE 16'h0008
`define LOCK_PAIRS 4'h8
`endif

// ===== core/tick_divider.v
// Divide a stream of tick pulses by a programmable ratio of limit plus one
`timescale 1ns/1ps
module tick_divider (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire clear,
  input wire tick_in,
  input wire [3:0] limit,
  // Divided tick
  output reg tick_out
);
  reg [3:0] count_q;

  always @(posedge clock) begin
    if (!rst_n || clear) begin
      count_q <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_q >= limit) begin
          count_q <= 4'h0;
          tick_out <= 1'b1;
        end else begin
          count_q <= count_q + 4'h1;
        end
      end
    end
  end
endmodule

// ===== core/clock_controller.v
// Clock controller: oscillator tick, core and peripheral enables, USB PLL and its registers
`timescale 1ns/1ps
`include "clkctl_defs.vh"

module clock_controller (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  // Oscillator pin and power state
  input wire oscillator_input_pin,
  input wire idle_mode,
  input wire power_down_mode,
  output reg osc_inverter_en_q,
  // Clock enables
  output reg core_clk_en_q,
  output reg periph_clk_en_q,
  output reg usb_clk_en_q,
  // Per-peripheral enables: two-wire, watchdog, counter array, serial, timer2..0, spi
  output reg [7:0] periph_sel_en_q,
  // Phase detector state
  output reg pll_up_q,
  output reg pll_down_q
);
  reg [7:0] clock_speed_control_0_q;
  reg spi_speed_sel_q;
  reg pll_enable_bit_q;
  reg external_48mhz_bypass_q;
  reg lock_indicator_q;
  reg [7:0] pll_divider_q;
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg half_q;
  reg [7:0] vco_period_q;
  reg [7:0] vco_cnt_q;
  reg vco_tick_q;
  reg ref_lead_q;
  reg fb_lead_q;
  reg [15:0] err_q;
  reg [3:0] good_q;
  reg [7:0] speed_d;
  reg [7:0] rdata_d;
  wire osc_tick;
  wire half_tick;
  wire double_speed;
  wire base_tick;
  wire pll_run;
  wire ref_tick;
  wire fb_tick;
  wire pair_done;
  wire ref_led;
  wire fb_led;
  wire [31:0] vco_period_full;
  integer i;

  assign double_speed = clock_speed_control_0_q[`BIT_DOUBLE_SPEED];

  // Oscillator pin synchroniser; third stage only for edge detection
  always @(posedge clock) begin
    if (!rst_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= oscillator_input_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Crystal or external 48 MHz both arrive on the same pin
  assign osc_tick = osc_s2_q & ~osc_s3_q;
  assign half_tick = osc_tick & half_q;
  assign base_tick = double_speed ? osc_tick : half_tick;

  always @(posedge clock) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else if (osc_tick) begin
      half_q <= ~half_q;
    end
  end

  // Register writes
  always @(posedge clock) begin
    if (!rst_n) begin
      clock_speed_control_0_q <= `RST_CLOCK_SPEED_CONTROL_0;
      spi_speed_sel_q <= `RST_CLOCK_SPEED_CONTROL_1;
      pll_enable_bit_q <= 1'b0;
      external_48mhz_bypass_q <= 1'b0;
      pll_divider_q <= `RST_PLL_DIVIDER;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `ADDR_CLOCK_SPEED_CONTROL_0: begin
          clock_speed_control_0_q <= sfr_wdata;
        end
        `ADDR_CLOCK_SPEED_CONTROL_1: begin
          spi_speed_sel_q <= sfr_wdata[`BIT_SPI_SPEED];
        end
        `ADDR_PLL_CONTROL: begin
          // Lock bit has no write path
          pll_enable_bit_q <= sfr_wdata[`BIT_PLL_ENABLE];
          external_48mhz_bypass_q <= sfr_wdata[`BIT_BYPASS_48];
        end
        `ADDR_PLL_DIVIDER: begin
          pll_divider_q <= sfr_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    case (sfr_addr)
      `ADDR_CLOCK_SPEED_CONTROL_0: rdata_d = clock_speed_control_0_q;
      `ADDR_CLOCK_SPEED_CONTROL_1: rdata_d = {7'h00, spi_speed_sel_q};
      `ADDR_PLL_CONTROL: begin
        rdata_d = {5'h00, external_48mhz_bypass_q, pll_enable_bit_q, lock_indicator_q};
      end
      `ADDR_PLL_DIVIDER: rdata_d = pll_divider_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered so the bus sees a stable byte until the next read
  always @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rdata_d;
    end
  end

  // Per-peripheral rate: fast only when double speed and its bit clear
  always @* begin
    speed_d = {clock_speed_control_0_q[7:1], spi_speed_sel_q};
    for (i = 0; i < 8; i = i + 1) begin
      speed_d[i] = double_speed ? (speed_d[i] ? half_tick : osc_tick) : half_tick;
    end
  end

  // Core, peripheral and USB enables under power state
  always @(posedge clock) begin
    if (!rst_n) begin
      core_clk_en_q <= 1'b0;
      periph_clk_en_q <= 1'b0;
      periph_sel_en_q <= 8'h00;
      usb_clk_en_q <= 1'b0;
      osc_inverter_en_q <= 1'b1;
    end else begin
      core_clk_en_q <= base_tick & ~idle_mode & ~power_down_mode;
      periph_clk_en_q <= base_tick & ~power_down_mode;
      periph_sel_en_q <= power_down_mode ? 8'h00 : speed_d;
      // Bypass passes the pin clock straight to USB
      if (power_down_mode) begin
        usb_clk_en_q <= 1'b0;
      end else if (external_48mhz_bypass_q) begin
        usb_clk_en_q <= osc_tick;
      end else begin
        usb_clk_en_q <= vco_tick_q;
      end
      osc_inverter_en_q <= ~external_48mhz_bypass_q;
    end
  end

  // Digital model of the loop: a period counter stands in for the oscillator
  assign pll_run = pll_enable_bit_q & ~external_48mhz_bypass_q;
  // Nominal period is a 32-bit quotient; only the low byte is meaningful
  assign vco_period_full = `VCO_PERIOD_INIT;

  // A one-count phase kick beside the period step damps the loop; the
  // period step alone swings wider than the lock window and never settles.
  // Limitation: with a large feedback ratio the period step dominates again.
  always @(posedge clock) begin
    if (!rst_n || !pll_run) begin
      vco_cnt_q <= 8'h00;
      vco_tick_q <= 1'b0;
    end else if (vco_cnt_q + 8'h01 >= vco_period_q) begin
      vco_cnt_q <= 8'h00;
      vco_tick_q <= 1'b1;
    end else if (fb_led) begin
      // Feedback early: hold the count for one cycle
      vco_cnt_q <= vco_cnt_q;
      vco_tick_q <= 1'b0;
    end else if (ref_led && vco_cnt_q + 8'h02 < vco_period_q) begin
      // Feedback late: step two counts at once
      vco_cnt_q <= vco_cnt_q + 8'h02;
      vco_tick_q <= 1'b0;
    end else begin
      vco_cnt_q <= vco_cnt_q + 8'h01;
      vco_tick_q <= 1'b0;
    end
  end

  // Reference from the peripheral clock, feedback from the PLL output
  tick_divider u_ref_div (
    .clock(clock),
    .rst_n(rst_n),
    .clear(~pll_run),
    .tick_in(periph_clk_en_q),
    .limit(pll_divider_q[`FIELD_REFERENCE_HI:`FIELD_REFERENCE_LO]),
    .tick_out(ref_tick)
  );

  tick_divider u_fb_div (
    .clock(clock),
    .rst_n(rst_n),
    .clear(~pll_run),
    .tick_in(vco_tick_q),
    .limit(pll_divider_q[`FIELD_FEEDBACK_HI:`FIELD_FEEDBACK_LO]),
    .tick_out(fb_tick)
  );

  // A pair closes when the lagging edge arrives, or both coincide
  assign ref_led = ref_lead_q & fb_tick;
  assign fb_led = fb_lead_q & ref_tick;
  assign pair_done = ref_led | fb_led | (ref_tick & fb_tick);

  always @(posedge clock) begin
    if (!rst_n || !pll_run) begin
      ref_lead_q <= 1'b0;
      fb_lead_q <= 1'b0;
      pll_up_q <= 1'b0;
      pll_down_q <= 1'b0;
      err_q <= 16'h0000;
      vco_period_q <= vco_period_full[7:0];
    end else begin
      if (pair_done) begin
        ref_lead_q <= 1'b0;
        fb_lead_q <= 1'b0;
        err_q <= 16'h0000;
      end else begin
        if (ref_tick) begin
          ref_lead_q <= 1'b1;
        end
        if (fb_tick) begin
          fb_lead_q <= 1'b1;
        end
        // Saturates so a stalled loop cannot wrap back into tolerance
        if ((ref_lead_q || fb_lead_q) && err_q != 16'hffff) begin
          err_q <= err_q + 16'h0001;
        end
      end
      // Up while reference leads, down while feedback leads
      pll_up_q <= (ref_lead_q | ref_tick) & ~pair_done;
      pll_down_q <= (fb_lead_q | fb_tick) & ~pair_done;
      // Leading reference speeds the loop up, leading feedback slows it
      if (ref_led && vco_period_q > `VCO_PERIOD_MIN) begin
        vco_period_q <= vco_period_q - 8'h01;
      end else if (fb_led && vco_period_q < `VCO_PERIOD_MAX) begin
        vco_period_q <= vco_period_q + 8'h01;
      end
    end
  end

  // Eight close pairs in a row filter out a lucky crossing of the swing
  // Lock after enough close pairs, lost on the first wide one
  always @(posedge clock) begin
    if (!rst_n || !pll_run) begin
      good_q <= 4'h0;
      lock_indicator_q <= 1'b0;
    end else if (pair_done) begin
      if (err_q > `LOCK_TOLERANCE) begin
        good_q <= 4'h0;
        lock_indicator_q <= 1'b0;
      end else if (good_q >= `LOCK_PAIRS - 4'h1) begin
        lock_indicator_q <= 1'b1;
      end else begin
        good_q <= good_q + 4'h1;
      end
    end
  end
endmodule

// ===== tb/clkctl_properties.sv
// Port-level properties of the clock controller, bound to its top module
`timescale 1ns/1ps
module clkctl_properties (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  // Power state and enables
  input wire idle_mode,
  input wire power_down_mode,
  input wire osc_inverter_en_q,
  input wire core_clk_en_q,
  input wire periph_clk_en_q,
  input wire usb_clk_en_q,
  input wire [7:0] periph_sel_en_q,
  input wire pll_up_q,
  input wire pll_down_q
);
  // Shadows of written bits; the write lands on the same edge as in the design
  reg [7:0] c0_q;
  reg [7:0] dv_q;
  reg [1:0] pc_q;
  wire [3:0] hit = {sfr_addr == 8'h8f, sfr_addr == 8'ha3, sfr_addr == 8'ha4, sfr_addr == 8'haf};
  always @(posedge clock) begin
    if (!rst_n) begin
      c0_q <= 8'h00;
      dv_q <= 8'h00;
      pc_q <= 2'b00;
    end else if (sfr_wr) begin
      if (hit[3]) c0_q <= sfr_wdata;
      if (hit[1]) dv_q <= sfr_wdata;
      if (hit[2]) pc_q <= sfr_wdata[2:1];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  speed0_readback_a: assert property ($past(sfr_rd && hit[3]) |-> sfr_rdata_q == $past(c0_q))
    else $error("clock speed 0 readback wrong");
  divider_readback_a: assert property ($past(sfr_rd && hit[1]) |-> sfr_rdata_q == $past(dv_q))
    else $error("divider readback wrong");
  pll_ctrl_read_a: assert property ($past(sfr_rd && hit[2]) |-> sfr_rdata_q[7:1] == {5'h00, $past(pc_q)})
    else $error("pll control readback wrong");
  speed1_reserved_a: assert property ($past(sfr_rd && hit[0]) |-> sfr_rdata_q[7:1] == 7'h00)
    else $error("clock speed 1 reserved bits set");
  unmapped_read_a: assert property ($past(sfr_rd && hit == 4'h0) |-> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  lock_needs_pll_a: assert property ($past(sfr_rd && hit[2]) && $past(pc_q) != 2'b01 &&
    $past(pc_q, 2) != 2'b01 |-> !sfr_rdata_q[0]) else $error("lock set while pll off");
  pll_stopped_a: assert property ($past(pc_q) != 2'b01 && $past(pc_q, 2) != 2'b01 &&
    $past(pc_q, 3) != 2'b01 |-> !pll_up_q && !pll_down_q) else $error("detector active while pll off");
  osc_follows_bypass_a: assert property (osc_inverter_en_q == !$past(pc_q[1]))
    else $error("oscillator enable wrong");
  pd_stops_clocks_a: assert property (power_down_mode [*3] |-> !core_clk_en_q && !periph_clk_en_q &&
    !usb_clk_en_q && periph_sel_en_q == 8'h00) else $error("clock during power-down");
  idle_stops_core_a: assert property (idle_mode [*3] |-> !core_clk_en_q)
    else $error("core clock during idle");
  sel_within_periph_a: assert property ((periph_sel_en_q & {8{!periph_clk_en_q}}) == 8'h00)
    else $error("peripheral pulse off the peripheral clock");
  up_down_excl_a: assert property (!(pll_up_q && pll_down_q))
    else $error("up and down together");
endmodule

bind clock_controller clkctl_properties chk (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
  .idle_mode(idle_mode), .power_down_mode(power_down_mode), .osc_inverter_en_q(osc_inverter_en_q),
  .core_clk_en_q(core_clk_en_q), .periph_clk_en_q(periph_clk_en_q), .usb_clk_en_q(usb_clk_en_q),
  .periph_sel_en_q(periph_sel_en_q), .pll_up_q(pll_up_q), .pll_down_q(pll_down_q));

// ===== tb/tb_top.sv
// Self-checking testbench of the clock controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  localparam [39:0] AMAP = 40'h8e_af_a4_a3_8f;
  localparam [23:0] CORN = 24'hff_01_00;
  reg clock = 0;
  reg rst_n = 0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_wr = 0, sfr_rd = 0, pin = 0, idle = 0, pd = 0, s1 = 0;
  reg [7:0] c0 = 8'h00, dv = 8'h00, rv, d, a;
  reg [1:0] pc = 2'b00;
  wire [7:0] rdata, sel;
  wire osc_en, core_en, per_en, usb_en;
  integer seed = 21183, error_cnt = 0, check_count = 0, k, i, n_core, n_per, n_usb;
  integer n_sel [0:7];
  clock_controller DUT (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(rdata), .oscillator_input_pin(pin), .idle_mode(idle),
    .power_down_mode(pd), .osc_inverter_en_q(osc_en), .core_clk_en_q(core_en), .periph_clk_en_q(per_en),
    .usb_clk_en_q(usb_en), .periph_sel_en_q(sel), .pll_up_q(), .pll_down_q());
  initial forever #2.5 clock = ~clock;
  // Oscillator pin period of 6 system clocks, so 240 cycles hold 40 ticks
  initial forever begin
    repeat (3) @(posedge clock);
    #1 pin = ~pin;
  end
  function [7:0] exp_rd(input [7:0] ad);
    case (ad)
      8'h8f: exp_rd = c0;
      8'ha3: exp_rd = {5'h00, pc, 1'b0};
      8'ha4: exp_rd = dv;
      8'haf: exp_rd = {7'h00, s1};
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task wr(input [7:0] ad, input [7:0] dt);
    begin
      @(posedge clock);
      #1 sfr_addr = ad;
      sfr_wdata = dt;
      sfr_wr = 1;
      @(posedge clock);
      #1 sfr_wr = 0;
      if (ad == 8'h8f) c0 = dt;
      if (ad == 8'ha3) pc = dt[2:1];
      if (ad == 8'ha4) dv = dt;
      if (ad == 8'haf) s1 = dt[0];
    end
  endtask
  task rd(input [7:0] ad, output [7:0] q);
    begin
      @(posedge clock);
      #1 sfr_addr = ad;
      sfr_rd = 1;
      @(posedge clock);
      #1 sfr_rd = 0;
      q = rdata;
    end
  endtask
  // Window edges may cut one pulse either way
  task near(input integer got, input integer e);
    `CHK((got >= e - 1 && got <= e + 1) ? e : got, e)
  endtask
  task count_win;
    begin
      n_core = 0;
      n_per = 0;
      n_usb = 0;
      for (i = 0; i < 8; i++) n_sel[i] = 0;
      repeat (240) begin
        @(posedge clock);
        #1;
        n_core += core_en;
        n_per += per_en;
        n_usb += usb_en;
        for (i = 0; i < 8; i++) n_sel[i] += sel[i];
      end
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clock);
    `CHK(osc_en, 1'b1)
    #1 rst_n = 1;
    for (k = 0; k < 25; k++) begin
      a = AMAP[8 * (k % 5) +: 8];
      d = $random(seed);
      if (k >= 5) wr(a, d);
      rd(a, rv);
      `CHK(rv & (a == 8'ha3 ? 8'hfe : 8'hff), exp_rd(a))
    end
    for (k = 0; k < 8; k++) begin
      d = $random(seed);
      if (k < 3) d = CORN[8 * k +: 8];
      idle = (k == 3);
      pd = (k == 4);
      wr(8'h8f, d);
      wr(8'haf, {7'h00, d[3] ^ d[5]});
      count_win;
      near(n_core, (idle | pd) ? 0 : (c0[0] ? 40 : 20));
      near(n_per, pd ? 0 : (c0[0] ? 40 : 20));
      for (i = 0; i < 8; i++) near(n_sel[i], pd ? 0 : ((c0[0] && !(i == 0 ? s1 : c0[i])) ? 40 : 20));
      if (pd) near(n_usb, 0);
    end
    idle = 0;
    pd = 0;
    wr(8'h8f, 8'h00);
    wr(8'ha3, 8'h00);
    wr(8'ha4, 8'h30);
    rd(8'ha4, rv);
    `CHK(rv, 8'h30)
    // Ratio one: the modelled USB rate equals the reference rate
    wr(8'ha4, 8'h00);
    wr(8'ha3, 8'h02);
    rv = 8'h00;
    for (k = 0; k < 500 && rv[0] !== 1'b1; k++) rd(8'ha3, rv);
    `CHK(rv[0], 1'b1)
    count_win;
    `CHK((n_usb >= 18 && n_usb <= 22) ? 20 : n_usb, 20)
    wr(8'ha3, 8'h06);
    rd(8'ha3, rv);
    `CHK(rv, 8'h06)
    `CHK(osc_en, 1'b0)
    count_win;
    near(n_usb, 40);
    wr(8'ha3, 8'hf9);
    rd(8'ha3, rv);
    `CHK(rv, 8'h00)
    `CHK(osc_en, 1'b1)
    close_out;
  end
endmodule
